// ===== rtl/ssp_cfg.svh
// Constants of the serial slave port: counts, framing values and reset values.
// Assumes inclusion by bare name from every file that needs them.
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// Core clock rate and the fastest serial clock the port accepts.
`define SSP_CLK_KHZ 250000
`define SSP_SCLK_MAX_KHZ 3500
// Least serial clock period in core cycles, rounded up.
`define SSP_SCLK_MIN_CYC ((`SSP_CLK_KHZ + `SSP_SCLK_MAX_KHZ - 1) / `SSP_SCLK_MAX_KHZ)
// Width of the serial clock period counter.
`define SSP_GAP_W 7
`define SSP_GAP_MAX 7'h7f

// Byte width and transmit queue depth.
`define SSP_BYTE_W 8
`define SSP_FIFO_DEPTH 16

// Frame start value and the one framing mode the port speaks.
`define SSP_API_DELIM 8'h7e
`define SSP_API_MODE 2'h1

// Bit counter value of the last bit in a byte.
`define SSP_BIT_LAST 3'h7

// Idle levels of the synchronised inputs {sleep_line, mosi, sclk, select_n}.
`define SSP_SYNC_RST 4'h1

`endif

// ===== rtl/ssp_pkg.sv
// Types shared by the serial slave port modules.
// Assumes nothing of its surroundings.
package ssp_pkg;

  // Serial port ownership after reset.
  typedef enum logic [3:0] {
    PORT_INIT = 4'b0001,
    PORT_WAIT = 4'b0010,
    PORT_SPI  = 4'b0100,
    PORT_UART = 4'b1000
  } ssp_port_t;

  // Receive frame tracker.
  typedef enum logic [3:0] {
    RX_HUNT   = 4'b0001,
    RX_LEN_HI = 4'b0010,
    RX_LEN_LO = 4'b0100,
    RX_BODY   = 4'b1000
  } ssp_rx_t;

endpackage : ssp_pkg

// ===== rtl/ssp_stream_if.sv
// Valid/ready byte stream between the port's own modules.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface ssp_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  // The producing end.
  modport src (output valid, output data, input ready);
  // The consuming end.
  modport snk (input valid, input data, output ready);
endinterface : ssp_stream_if

`default_nettype wire

// ===== rtl/ssp_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; output changes only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module ssp_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Raw and filtered levels.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_q, s2_q, s3_q, q_q, q_d;

  // A bit takes the new level once the later two stages hold the same value.
  always_comb begin
    q_d = q_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        q_d[i] = s3_q[i];
      end
    end
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      q_q <= RST;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q <= q_d;
    end
  end

  assign q = q_q;

  AST_SYNC_AGREE: assert property (@(posedge clock) disable iff (!rstn)
    (s2_q == s3_q) |=> (q == $past(s3_q)))
    else $error("synchroniser output missed an agreed level");

endmodule : ssp_sync

`default_nettype wire

// ===== rtl/ssp_fifo.sv
// Byte queue with valid/ready on both sides and registered flags.
// Assumes one clock; DEPTH is a power of two.
`timescale 1ns/1ps
`default_nettype none

module ssp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Fill and drain sides.
  ssp_stream_if.snk wr,
  ssp_stream_if.src rd
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic full_q, full_d, empty_q, empty_d;
  logic push, pop;

  // Pointers and count move on accepted transfers; flags follow the next count.
  always_comb begin
    push = wr.valid && !full_q;
    pop = rd.ready && !empty_q;
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    full_d = (cnt_d == (AW + 1)'(DEPTH));
    empty_d = (cnt_d == '0);
  end

  // Pointer, count and flag registers.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      full_q <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      full_q <= full_d;
      empty_q <= empty_d;
    end
  end

  // The array itself carries no reset.
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wp_q] <= wr.data;
    end
  end

  assign wr.ready = !full_q;
  assign rd.valid = !empty_q;
  assign rd.data = mem_q[rp_q];

endmodule : ssp_fifo

`default_nettype wire

// ===== rtl/ssp_slave.sv
// Serial slave port: mode 0 shifter, transmit queue, attention line, frame filter and pin sleep.
// Assumes an outside master drives sclk_pin, ssel_n_pin and mosi_pin; all three are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_cfg.svh"

module ssp_slave (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Serial link pins.
  input wire logic sclk_pin,
  input wire logic ssel_n_pin,
  input wire logic mosi_pin,
  output logic miso_o,
  output logic miso_oe,
  output logic attention_out,
  // Configuration levels.
  input wire logic uart_enabled,
  input wire logic spi_enabled,
  input wire logic uart_rx_seen,
  input wire logic sleep_pin_periph,
  input wire logic ssel_periph,
  input wire logic sleep_pin_line,
  input wire logic [1:0] api_setting,
  // Transmit byte stream.
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // Receive byte stream.
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_sof,
  // Status.
  output logic spi_active,
  output logic asleep,
  output logic [1:0] api_mode,
  output logic sclk_fast
);

  // ****************************************************************
  // Input synchronisation and edge detection
  // ****************************************************************

  logic [3:0] pins_f;
  logic ssel_f, sclk_f, mosi_f, sleep_f;
  logic ssel_p_q, sclk_p_q;
  logic sel_fall, rise, fall;

  // All link pins pass the filter before any use.
  ssp_sync #(.W(4), .RST(`SSP_SYNC_RST)) u_sync (
    .clock(clock),
    .rstn(rstn),
    .d({sleep_pin_line, mosi_pin, sclk_pin, ssel_n_pin}),
    .q(pins_f)
  );

  // Edges are taken from the filtered levels only.
  always_comb begin
    ssel_f = pins_f[0];
    sclk_f = pins_f[1];
    mosi_f = pins_f[2];
    sleep_f = pins_f[3];
    sel_fall = ssel_p_q && !ssel_f;
    rise = !sclk_p_q && sclk_f && !ssel_f;
    fall = sclk_p_q && !sclk_f && !ssel_f;
  end

  // Previous filtered levels.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ssel_p_q <= 1'b1;
      sclk_p_q <= 1'b0;
    end else begin
      ssel_p_q <= ssel_f;
      sclk_p_q <= sclk_f;
    end
  end

  // ****************************************************************
  // Port ownership
  // ****************************************************************

  ssp_pkg::ssp_port_t port_q, port_d;
  logic is_spi;

  // Decides once after reset, then holds until the next reset.
  always_comb begin
    port_d = port_q;
    unique case (port_q)
      ssp_pkg::PORT_INIT: begin
        if (spi_enabled && !uart_enabled) begin
          port_d = ssp_pkg::PORT_SPI;
        end else if (spi_enabled && uart_enabled) begin
          port_d = ssp_pkg::PORT_WAIT;
        end else begin
          port_d = ssp_pkg::PORT_UART;
        end
      end
      ssp_pkg::PORT_WAIT: begin
        if (sel_fall) begin
          port_d = ssp_pkg::PORT_SPI;
        end else if (uart_rx_seen) begin
          port_d = ssp_pkg::PORT_UART;
        end
      end
      ssp_pkg::PORT_SPI: port_d = ssp_pkg::PORT_SPI;
      ssp_pkg::PORT_UART: port_d = ssp_pkg::PORT_UART;
      default: port_d = ssp_pkg::PORT_INIT;
    endcase
    is_spi = (port_d == ssp_pkg::PORT_SPI);
  end

  // Ownership register.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      port_q <= ssp_pkg::PORT_INIT;
    end else begin
      port_q <= port_d;
    end
  end

  // ****************************************************************
  // Transmit queue and shifter
  // ****************************************************************

  ssp_stream_if #(.W(`SSP_BYTE_W)) q_in ();
  ssp_stream_if #(.W(`SSP_BYTE_W)) q_out ();

  ssp_fifo #(.W(`SSP_BYTE_W), .DEPTH(`SSP_FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .wr(q_in.snk),
    .rd(q_out.src)
  );

  assign q_in.valid = tx_valid;
  assign q_in.data = tx_data;
  assign tx_ready = q_in.ready;

  logic [7:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d, rx_byte;
  logic [2:0] bit_q, bit_d;
  logic load_pend_q, load_pend_d, live_q, live_d;
  logic miso_q, miso_d, oe_q, oe_d, attn_q, attn_d;
  logic load, byte_done;

  // Loads a byte at select and after each eighth rising edge; shifts on falling edges.
  always_comb begin
    tx_sh_d = tx_sh_q;
    rx_sh_d = rx_sh_q;
    bit_d = bit_q;
    load_pend_d = load_pend_q;
    live_d = live_q;
    miso_d = miso_q;
    load = 1'b0;
    byte_done = 1'b0;
    rx_byte = {rx_sh_q[6:0], mosi_f};
    if (is_spi) begin
      if (sel_fall) begin
        bit_d = 3'h0;
        load = 1'b1;
      end else if (rise) begin
        rx_sh_d = rx_byte;
        bit_d = bit_q + 3'h1;
        if (bit_q == `SSP_BIT_LAST) begin
          byte_done = 1'b1;
          load_pend_d = 1'b1;
          live_d = 1'b0;
        end
      end else if (fall) begin
        if (load_pend_q) begin
          load = 1'b1;
        end else begin
          tx_sh_d = {tx_sh_q[6:0], tx_sh_q[0]};
          miso_d = tx_sh_q[6];
        end
      end
      if (load) begin
        load_pend_d = 1'b0;
        if (q_out.valid) begin
          tx_sh_d = q_out.data;
          live_d = 1'b1;
          miso_d = q_out.data[7];
        end else begin
          tx_sh_d = {8{miso_q}};
          live_d = 1'b0;
        end
      end
    end
    q_out.ready = load;
    oe_d = is_spi && !ssel_f;
    attn_d = !(is_spi && (q_out.valid || live_d));
  end

  // Shifter registers; attention resets high, the line resets released.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_sh_q <= 8'h00;
      rx_sh_q <= 8'h00;
      bit_q <= 3'h0;
      load_pend_q <= 1'b0;
      live_q <= 1'b0;
      miso_q <= 1'b0;
      oe_q <= 1'b0;
      attn_q <= 1'b1;
    end else begin
      tx_sh_q <= tx_sh_d;
      rx_sh_q <= rx_sh_d;
      bit_q <= bit_d;
      load_pend_q <= load_pend_d;
      live_q <= live_d;
      miso_q <= miso_d;
      oe_q <= oe_d;
      attn_q <= attn_d;
    end
  end

  assign miso_o = miso_q;
  assign miso_oe = oe_q;
  assign attention_out = attn_q;

  // ****************************************************************
  // Receive frame filter
  // ****************************************************************

  ssp_pkg::ssp_rx_t rx_st_q, rx_st_d;
  logic [7:0] len_hi_q, len_hi_d, rx_data_q, rx_data_d;
  logic [16:0] left_q, left_d;
  logic rx_valid_q, rx_valid_d, rx_sof_q, rx_sof_d;

  // Passes frame bytes, delimiter to checksum; drops filler between frames.
  always_comb begin
    rx_st_d = rx_st_q;
    len_hi_d = len_hi_q;
    left_d = left_q;
    rx_data_d = rx_data_q;
    rx_valid_d = 1'b0;
    rx_sof_d = 1'b0;
    if (byte_done) begin
      rx_data_d = rx_byte;
      unique case (rx_st_q)
        ssp_pkg::RX_HUNT: begin
          if (rx_byte == `SSP_API_DELIM) begin
            rx_st_d = ssp_pkg::RX_LEN_HI;
            rx_valid_d = 1'b1;
            rx_sof_d = 1'b1;
          end
        end
        ssp_pkg::RX_LEN_HI: begin
          len_hi_d = rx_byte;
          rx_valid_d = 1'b1;
          rx_st_d = ssp_pkg::RX_LEN_LO;
        end
        ssp_pkg::RX_LEN_LO: begin
          left_d = {1'b0, len_hi_q, rx_byte} + 17'h0_0001; // Payload plus checksum.
          rx_valid_d = 1'b1;
          rx_st_d = ssp_pkg::RX_BODY;
        end
        ssp_pkg::RX_BODY: begin
          left_d = left_q - 17'h0_0001;
          rx_valid_d = 1'b1;
          if (left_q == 17'h0_0001) begin
            rx_st_d = ssp_pkg::RX_HUNT;
          end
        end
        default: rx_st_d = ssp_pkg::RX_HUNT;
      endcase
    end
  end

  // Frame filter registers.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_st_q <= ssp_pkg::RX_HUNT;
      len_hi_q <= 8'h00;
      left_q <= 17'h0_0000;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
      rx_sof_q <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      len_hi_q <= len_hi_d;
      left_q <= left_d;
      rx_data_q <= rx_data_d;
      rx_valid_q <= rx_valid_d;
      rx_sof_q <= rx_sof_d;
    end
  end

  assign rx_valid = rx_valid_q;
  assign rx_data = rx_data_q;
  assign rx_sof = rx_sof_q;

  // ****************************************************************
  // Sleep control, clock rate check and status
  // ****************************************************************

  logic [`SSP_GAP_W-1:0] gap_q, gap_d;
  logic fast_q, fast_d, sleep_q, sleep_d, spi_q, spi_d;
  logic [1:0] mode_q, mode_d;

  // Sleep source priority, period check between rising edges, status flags.
  always_comb begin
    if (sleep_pin_periph) begin
      sleep_d = sleep_f;
    end else if (ssel_periph) begin
      sleep_d = ssel_f;
    end else begin
      sleep_d = 1'b0;
    end
    gap_d = (gap_q == `SSP_GAP_MAX) ? gap_q : gap_q + 1'b1;
    fast_d = fast_q;
    if (sel_fall) begin
      gap_d = `SSP_GAP_MAX;
      fast_d = 1'b0;
    end
    // A rising edge in the cycle of the select fall still flags a fast clock: the set wins.
    if (rise) begin
      gap_d = '0;
      if (gap_q < `SSP_GAP_W'(`SSP_SCLK_MIN_CYC - 1)) begin
        fast_d = 1'b1;
      end
    end
    spi_d = is_spi;
    mode_d = `SSP_API_MODE;
  end

  // Status registers.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gap_q <= `SSP_GAP_MAX;
      fast_q <= 1'b0;
      sleep_q <= 1'b0;
      spi_q <= 1'b0;
      mode_q <= `SSP_API_MODE;
    end else begin
      gap_q <= gap_d;
      fast_q <= fast_d;
      sleep_q <= sleep_d;
      spi_q <= spi_d;
      mode_q <= mode_d;
    end
  end

  assign asleep = sleep_q;
  assign spi_active = spi_q;
  assign api_mode = mode_q;
  assign sclk_fast = fast_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_delim;
    byte_done && (rx_st_q == ssp_pkg::RX_HUNT) && (rx_byte == `SSP_API_DELIM);
  endsequence

  sequence s_live_load;
    load && q_out.valid;
  endsequence

  AST_MISO_RELEASE: assert property (ssel_f |=> !miso_oe)
    else $error("line driven while deselected");
  AST_MISO_DRIVE: assert property ((spi_q && is_spi && !ssel_f) |=> miso_oe)
    else $error("line not driven while selected");
  AST_ATTN_QUEUED: assert property ((is_spi && q_out.valid) |=> !attention_out)
    else $error("attention high with bytes queued");
  AST_ATTN_IDLE: assert property ((port_d != ssp_pkg::PORT_SPI) |=> attention_out)
    else $error("attention low while port not owned");
  AST_MSB_FIRST: assert property (s_live_load |=> (miso_o == $past(q_out.data[7])))
    else $error("first bit is not the top bit");
  AST_SHIFT_FALL: assert property ((fall && is_spi && !load_pend_q) |=> (miso_o == $past(tx_sh_q[6])))
    else $error("line did not advance on falling edge");
  AST_REPEAT_BIT: assert property ((load && !q_out.valid) |=> $stable(miso_o))
    else $error("empty queue did not repeat last bit");
  AST_SLEEP_SEL: assert property ((!sleep_pin_periph && ssel_periph) |=> (asleep == $past(ssel_f)))
    else $error("select did not steer sleep");
  AST_AWAKE: assert property ((!sleep_pin_periph && !ssel_periph) |=> !asleep)
    else $error("slept with no sleep pin");
  AST_PORT_LOCK: assert property ((port_q == ssp_pkg::PORT_UART) |=> (port_q == ssp_pkg::PORT_UART)[*2])
    else $error("port ownership changed after lock");
  AST_FRAME_START: assert property (s_delim |=> (rx_valid && rx_sof && (rx_data == `SSP_API_DELIM)))
    else $error("frame start not reported");
  AST_FILLER: assert property ((byte_done && (rx_st_q == ssp_pkg::RX_HUNT) && (rx_byte != `SSP_API_DELIM))
    |=> !rx_valid)
    else $error("filler byte passed on");

endmodule : ssp_slave

`default_nettype wire

// ===== dv/ssp_host_model.sv
// Host model: a mode 0 serial master that selects, clocks and exchanges bytes.
// Assumes the bench resolves the data-out line and calls one task at a time.
`timescale 1ns/1ps
`default_nettype none

module ssp_host_model (
  // Serial link lines.
  output logic sclk,
  output logic ssel_n,
  output logic mosi,
  input wire logic miso
);
  // Idle lines: clock low, select high, data released to its pull-up level.
  initial begin
    sclk = 1'b0;
    ssel_n = 1'b1;
    mosi = 1'b1;
  end

  // Drops select off the core clock grid, then waits before the first edge.
  task automatic select();
    #3.3 ssel_n = 1'b0;
    #80;
  endtask : select

  // Raises select and releases the data line.
  task automatic deselect();
    #80 ssel_n = 1'b1;
    mosi = 1'b1;
  endtask : deselect

  // Exchanges one byte at 160 ns per bit, sampling on the rising edge.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #80 sclk = 1'b1;
      rx[i] = miso;
      #80 sclk = 1'b0;
    end
  endtask : xfer
endmodule : ssp_host_model

`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench of the serial slave port with a host master model.
// Assumes the design package, config header and host model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clock, rstn, sclk, ssel_n, mosi, miso_o, miso_oe, attention_out;
  logic uart_enabled, spi_enabled, uart_rx_seen, sleep_pin_periph, ssel_periph, sleep_pin_line;
  logic [1:0] api_setting, api_mode;
  logic tx_valid, tx_ready, rx_valid, rx_sof, spi_active, asleep, sclk_fast;
  logic [7:0] tx_data, rx_data, got;
  wire miso;
  logic [7:0] rxq[$];
  int n_mismatch = 0;
  int n_checks = 0;
  int n_sof = 0;

  // ******************************************************
  // Design, host and line resolution
  // ******************************************************
  ssp_slave uut (.clock(clock), .rstn(rstn), .sclk_pin(sclk), .ssel_n_pin(ssel_n), .mosi_pin(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe), .attention_out(attention_out), .uart_enabled(uart_enabled),
    .spi_enabled(spi_enabled), .uart_rx_seen(uart_rx_seen), .sleep_pin_periph(sleep_pin_periph),
    .ssel_periph(ssel_periph), .sleep_pin_line(sleep_pin_line), .api_setting(api_setting),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_sof(rx_sof), .spi_active(spi_active), .asleep(asleep), .api_mode(api_mode), .sclk_fast(sclk_fast));
  ssp_host_model host (.sclk(sclk), .ssel_n(ssel_n), .mosi(mosi), .miso(miso));
  // The data-out line floats when the port lets go of it.
  assign miso = miso_oe ? miso_o : 1'bz;

  // ******************************************************
  // Clock, watchdog, monitor and tasks
  // ******************************************************
  // Core clock of 4 ns.
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #300000;
    n_mismatch++;
    test_done();
  end

  // Collects every received frame byte mid-cycle, away from the edge that launches it.
  always @(negedge clock) begin
    if (rx_valid === 1'b1) begin
      rxq.push_back(rx_data);
      if (rx_sof === 1'b1) n_sof++;
    end
  end

  // Compares a seen value with its expected value.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Waits a number of core cycles, ending just after an edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  // Resets the port with the given port enables.
  task automatic do_reset(input logic ue, input logic se);
    rstn = 1'b0;
    uart_enabled = ue;
    spi_enabled = se;
    cyc(3);
    rstn = 1'b1;
  endtask : do_reset

  // Hands one byte to the transmit queue, holding it until taken, then leaves one idle edge.
  task automatic push(input logic [7:0] b);
    tx_valid = 1'b1;
    tx_data = b;
    while (tx_ready !== 1'b1) cyc(1);
    cyc(1);
    tx_valid = 1'b0;
    cyc(1);
  endtask : push

  // Outgoing frame: delimiter, length 11, then payload and checksum.
  function automatic logic [7:0] tx_b(input int i);
    return i == 0 ? 8'h7e : i == 1 ? 8'h00 : i == 2 ? 8'h0b : 8'(8'h10 + i);
  endfunction : tx_b

  // Host bytes: filler, a one-byte frame, then filler.
  function automatic logic [7:0] mo_b(input int i);
    logic [7:0] t[6] = '{8'h11, 8'h7e, 8'h00, 8'h01, 8'h55, 8'haa};
    return i < 6 ? t[i] : 8'h33;
  endfunction : mo_b

  // Prints the verdict and ends the run.
  task automatic test_done();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // ******************************************************
  // Test sequence
  // ******************************************************
  initial begin
    {uart_rx_seen, sleep_pin_periph, sleep_pin_line, tx_valid} = '0;
    ssel_periph = 1'b1;
    api_setting = 2'h0;
    tx_data = 8'h00;
    do_reset(1'b0, 1'b1);
    chk(8'(miso_oe), 8'h00);
    chk(8'(attention_out), 8'h01);
    chk(8'(tx_ready), 8'h01);
    chk(8'(sclk_fast), 8'h00);
    cyc(2);
    chk(8'(spi_active), 8'h01);
    api_setting = 2'h2;
    cyc(4);
    chk(8'(api_mode), 8'h01);
    chk(8'(asleep), 8'h01);
    push(tx_b(0));
    cyc(1);
    chk(8'(attention_out), 8'h00);
    for (int i = 1; i < 16; i++) push(tx_b(i));
    cyc(2);
    chk(8'(tx_ready), 8'h00);
    chk(8'(miso_oe), 8'h00);
    host.select();
    chk(8'(miso_oe), 8'h01);
    chk(8'(asleep), 8'h00);
    for (int i = 0; i < 17; i++) begin
      host.xfer(mo_b(i), got);
      chk(got, i < 16 ? tx_b(i) : 8'hff);
      if (i == 8) #1000;
      if (i == 14) chk(8'(attention_out), 8'h00);
      if (i == 15) begin
        cyc(10);
        chk(8'(attention_out), 8'h01);
      end
    end
    chk(8'(sclk_fast), 8'h01);
    host.deselect();
    cyc(10);
    chk(8'(miso_oe), 8'h00);
    chk(8'(asleep), 8'h01);
    chk(8'(rxq.size()), 8'h05);
    for (int i = 0; i < 5; i++) chk(rxq[i], mo_b(i + 1));
    chk(8'(n_sof), 8'h01);
    ssel_periph = 1'b0;
    sleep_pin_periph = 1'b1;
    sleep_pin_line = 1'b1;
    cyc(10);
    chk(8'(asleep), 8'h01);
    sleep_pin_line = 1'b0;
    cyc(10);
    chk(8'(asleep), 8'h00);
    sleep_pin_periph = 1'b0;
    sleep_pin_line = 1'b1;
    cyc(10);
    chk(8'(asleep), 8'h00);
    do_reset(1'b1, 1'b1);
    uart_rx_seen = 1'b1;
    cyc(2);
    uart_rx_seen = 1'b0;
    push(8'h7e);
    host.select();
    chk(8'(spi_active), 8'h00);
    chk(8'(attention_out), 8'h01);
    host.deselect();
    do_reset(1'b1, 1'b1);
    cyc(2);
    host.select();
    cyc(4);
    chk(8'(spi_active), 8'h01);
    host.deselect();
    cyc(10);
    test_done();
  end
endmodule : testbench

`default_nettype wire
